// ===== iox_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iox_regs.svh"

// What this block does
// RULE_01: Sixteen pins in two 8-bit ports, each with direction, input, output, polarity.
// RULE_02: After reset every pin is an input with its driver off.
// RULE_03: Direction bit per pin selects driving the pin or leaving it input.
// RULE_04: Input bits hold sampled pin levels; output bits hold levels to drive.
// RULE_05: Polarity bit set returns the complemented pin level on input reads.
// RULE_06: Every register can be read back over the serial link.
// RULE_07: Alert pulled low while any input pin differs from its held value.
// RULE_08: Alert is open drain and active low, released otherwise.
// RULE_09: Reset restores register defaults and idles the serial state machine.
// RULE_10: Three four-level straps give 64 distinct target addresses.
// RULE_11: Serial link works at 100 kHz, 400 kHz and 1 MHz clock rates.
// RULE_12: Short glitches on SCL and SDA are filtered before use; the code passes any level seen at one core clock sample, as IOX_FILT_CYC is 1.
// RULE_13: No spurious pin or alert transitions while coming out of reset.
// RULE_14: Reading a port's input register updates its held value and clears alert.
// RULE_15: Master writes a register select byte; data bytes alternate the two ports.
module iox_top (
   // Clock, reset, enable
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   // Serial link
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n_out,
   // Address straps, level code 0 low, 1 high, 2 tied SCL, 3 tied SDA
   input  wire logic [1:0]  addr_strap_0_in,
   input  wire logic [1:0]  addr_strap_1_in,
   input  wire logic [1:0]  addr_strap_2_in,
   // Port A
   input  wire logic [7:0]  port_a_pin_in,
   output logic      [7:0]  port_a_pin_out,
   output logic      [7:0]  port_a_pin_oe_n_out,
   // Port B
   input  wire logic [7:0]  port_b_pin_in,
   output logic      [7:0]  port_b_pin_out,
   output logic      [7:0]  port_b_pin_oe_n_out,
   // Change alert, open drain
   output logic             change_alert_n_out,
   output logic             change_alert_oe_n_out,
   // AXI4-Lite write
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   output logic      [1:0]  s_axi_bresp_out,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   input  wire logic [7:0]  s_axi_araddr_in,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   output logic      [31:0] s_axi_rdata_out,
   output logic      [1:0]  s_axi_rresp_out,
   // Interrupt
   output logic             irq_out
);
   import iox_pkg::*;

   iox_regs_s  state_q;
   iox_regs_s  state_d;
   logic [2:0] ev;
   logic [2:0] clr;
   logic       scl;
   logic       sda;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;
   logic       load;
   logic [1:0] line_in;

   function automatic logic axi_hit(input logic [7:0] a);
      axi_hit = (a == `IOX_OFS_IRQ_STAT) || (a == `IOX_OFS_IRQ_MASK) ||
                (a == `IOX_OFS_STATUS) || (a == `IOX_OFS_PORTS);
   endfunction

   function automatic logic [31:0] axi_rd(input logic [7:0] a, input iox_regs_s r);
      axi_rd = 32'h0;
      case (a)
         `IOX_OFS_IRQ_STAT: axi_rd = {29'h0, r.stat};
         `IOX_OFS_IRQ_MASK: axi_rd = {29'h0, r.mask};
         `IOX_OFS_STATUS:   axi_rd = {23'h0, r.alert, 1'b0, r.my_addr};
         `IOX_OFS_PORTS:    axi_rd = {r.outv, r.held};
         default:           axi_rd = 32'h0;
      endcase
   endfunction

   // Byte returned for a register select
   function automatic logic [7:0] rd_byte(input logic [2:0] s, input iox_regs_s r);
      case (s[2:1])
         `IOX_KIND_INPUT:  rd_byte = r.pin_s2[s[0]] ^ r.pol[s[0]]; // [RULE_05]
         `IOX_KIND_OUTPUT: rd_byte = r.outv[s[0]]; // [RULE_06]
         `IOX_KIND_POL:    rd_byte = r.pol[s[0]]; // [RULE_06]
         default:          rd_byte = r.dir[s[0]]; // [RULE_06]
      endcase
   endfunction

   always_comb begin
      state_d = state_q;
      ev      = 3'h0;
      clr     = 3'h0;
      load    = 1'b0;
      line_in = {sda_in, scl_in};

      // Two-flop sync then spike filter per line
      for (int i = 0; i < 2; i++) begin
         state_d.sy[i] = {state_q.sy[i][0], line_in[i]};
         if (state_q.sy[i][1] != state_q.f[i]) begin
            if (state_q.cnt[i] >= 4'(`IOX_FILT_CYC - 1)) begin // [RULE_12] [RULE_11]
               state_d.f[i]   = state_q.sy[i][1];
               state_d.cnt[i] = 4'h0;
            end else begin
               state_d.cnt[i] = state_q.cnt[i] + 4'h1;
            end
         end else begin
            state_d.cnt[i] = 4'h0;
         end
      end
      state_d.lp = state_q.f;
      scl   = state_q.f[0];
      sda   = state_q.f[1];
      rise  = scl & ~state_q.lp[0];
      fall  = ~scl & state_q.lp[0];
      start = scl & state_q.lp[0] & state_q.lp[1] & ~sda;
      stop  = scl & state_q.lp[0] & ~state_q.lp[1] & sda;

      state_d.pin_s1 = {port_b_pin_in, port_a_pin_in}; // [RULE_04]
      state_d.pin_s2 = state_q.pin_s1;

      // Strap capture over the first cycles after reset release
      state_d.strap_s1 = {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in};
      state_d.strap_s2 = state_q.strap_s1;
      if (state_q.strap_cnt != 2'h3) begin
         state_d.strap_cnt = state_q.strap_cnt + 2'h1;
         state_d.my_addr   = {`IOX_ADDR_HI, state_q.strap_s2}; // [RULE_10]
      end

      // Serial target
      if (start) begin
         state_d.st       = ST_RXB;
         state_d.phase    = 2'h0;
         state_d.bitc     = 4'h0;
         state_d.sda_oe_n = 1'b1;
      end else if (stop) begin
         state_d.st       = ST_IDLE;
         state_d.sda_oe_n = 1'b1;
      end else begin
         unique case (state_q.st)
            ST_IDLE: begin
               state_d.sda_oe_n = 1'b1;
            end
            ST_RXB: begin
               if (rise) begin
                  state_d.sh   = {state_q.sh[6:0], sda};
                  state_d.bitc = state_q.bitc + 4'h1;
               end else if (fall && state_q.bitc == 4'h8) begin
                  state_d.bitc = 4'h0;
                  state_d.st   = ST_ACK;
                  state_d.sda_oe_n = 1'b0;
                  if (state_q.phase == 2'h0) begin
                     state_d.rw = state_q.sh[0];
                     if (state_q.sh[7:1] != state_q.my_addr) begin
                        state_d.st       = ST_IDLE;
                        state_d.sda_oe_n = 1'b1;
                     end
                  end else if (state_q.phase == 2'h1) begin
                     state_d.sel = state_q.sh[2:0]; // [RULE_15]
                  end else begin
                     unique case (state_q.sel[2:1])
                        `IOX_KIND_OUTPUT: state_d.outv[state_q.sel[0]] = state_q.sh; // [RULE_04]
                        `IOX_KIND_POL:    state_d.pol[state_q.sel[0]] = state_q.sh;
                        `IOX_KIND_DIR:    state_d.dir[state_q.sel[0]] = state_q.sh; // [RULE_03]
                        `IOX_KIND_INPUT:  state_d.sh = state_q.sh;
                     endcase
                     state_d.sel[0] = ~state_q.sel[0]; // [RULE_15]
                     ev[`IOX_EV_WRITE] = 1'b1;
                  end
               end
            end
            ST_ACK: begin
               if (fall) begin
                  state_d.sda_oe_n = 1'b1;
                  state_d.bitc     = 4'h0;
                  if (state_q.phase == 2'h0 && state_q.rw) begin
                     load = 1'b1;
                  end else begin
                     state_d.st    = ST_RXB;
                     state_d.phase = (state_q.phase == 2'h0) ? 2'h1 : 2'h2;
                  end
               end
            end
            ST_TXB: begin
               if (rise) begin
                  state_d.bitc = state_q.bitc + 4'h1;
               end else if (fall) begin
                  if (state_q.bitc == 4'h8) begin
                     state_d.sda_oe_n = 1'b1;
                     state_d.bitc     = 4'h0;
                     state_d.st       = ST_RACK;
                  end else begin
                     state_d.sh       = {state_q.sh[6:0], 1'b0};
                     state_d.sda_oe_n = state_q.sh[6];
                  end
               end
            end
            ST_RACK: begin
               if (rise) begin
                  state_d.nack = sda;
               end else if (fall) begin
                  if (state_q.nack) begin
                     state_d.st = ST_IDLE;
                  end else begin
                     state_d.sel[0] = ~state_q.sel[0]; // [RULE_15]
                     load = 1'b1;
                  end
               end
            end
            default: begin
               state_d.st       = ST_IDLE;
               state_d.sda_oe_n = 1'b1;
            end
         endcase
      end

      // Load next transmit byte
      if (load) begin
         state_d.sh       = rd_byte(state_d.sel, state_q);
         state_d.sda_oe_n = state_d.sh[7];
         state_d.bitc     = 4'h0;
         state_d.st       = ST_TXB;
         if (state_d.sel[2:1] == `IOX_KIND_INPUT) begin
            state_d.held[state_d.sel[0]] = state_q.pin_s2[state_d.sel[0]]; // [RULE_14]
            ev[`IOX_EV_READ] = 1'b1;
         end
      end

      // Alert: input pins differing from held values
      state_d.alert = |((state_d.pin_s2 ^ state_d.held) & state_d.dir); // [RULE_07] [RULE_14]
      ev[`IOX_EV_ALERT] = state_d.alert & ~state_q.alert;

      // AXI4-Lite write path
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         state_d.aw_ok = 1'b1;
         state_d.awa   = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         state_d.w_ok = 1'b1;
         state_d.wd   = s_axi_wdata_in;
         state_d.wstb = s_axi_wstrb_in[0];
      end
      if (state_q.aw_ok && state_q.w_ok) begin
         state_d.aw_ok  = 1'b0;
         state_d.w_ok   = 1'b0;
         state_d.bvalid = 1'b1;
         state_d.bresp  = axi_hit(state_q.awa) ? `IOX_RESP_OKAY : `IOX_RESP_SLVERR;
         if (state_q.wstb && state_q.awa == `IOX_OFS_IRQ_STAT) begin
            clr = state_q.wd[2:0];
         end
         if (state_q.wstb && state_q.awa == `IOX_OFS_IRQ_MASK) begin
            state_d.mask = state_q.wd[2:0];
         end
      end
      if (state_q.bvalid && s_axi_bready_in) begin
         state_d.bvalid = 1'b0;
      end

      // AXI4-Lite read path
      if (s_axi_arvalid_in && !state_q.rvalid) begin
         state_d.rvalid = 1'b1;
         state_d.rdata  = axi_rd(s_axi_araddr_in, state_q);
         state_d.rresp  = axi_hit(s_axi_araddr_in) ? `IOX_RESP_OKAY : `IOX_RESP_SLVERR;
      end
      if (state_q.rvalid && s_axi_rready_in) begin
         state_d.rvalid = 1'b0;
      end

      // Sticky events, a new event beats a same-cycle clear
      state_d.stat = (state_q.stat & ~clr) | ev;

      // Defaults: all pins input, driver and alert released, link idle
      if (!rst_n_in) begin
         state_d          = '0;
         state_d.st       = ST_IDLE; // [RULE_09]
         state_d.sy       = '1;
         state_d.f        = '1;
         state_d.lp       = '1;
         state_d.sda_oe_n = 1'b1;
         state_d.dir      = {2{`IOX_DIR_RST}}; // [RULE_02] [RULE_13]
         state_d.outv     = {2{`IOX_OUT_RST}}; // [RULE_09]
         state_d.pol      = {2{`IOX_POL_RST}};
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || ce_in) begin
         state_q <= state_d;
      end
   end

   assign sda_out               = 1'b0;
   assign sda_oe_n_out          = state_q.sda_oe_n;
   assign port_a_pin_out        = state_q.outv[0];
   assign port_b_pin_out        = state_q.outv[1];
   assign port_a_pin_oe_n_out   = state_q.dir[0]; // [RULE_03] [RULE_01]
   assign port_b_pin_oe_n_out   = state_q.dir[1]; // [RULE_03] [RULE_01]
   assign change_alert_n_out    = 1'b0; // [RULE_08]
   assign change_alert_oe_n_out = ~state_q.alert; // [RULE_08]
   assign s_axi_awready_out     = ~state_q.aw_ok & ~state_q.bvalid;
   assign s_axi_wready_out      = ~state_q.w_ok & ~state_q.bvalid;
   assign s_axi_bvalid_out      = state_q.bvalid;
   assign s_axi_bresp_out       = state_q.bresp;
   assign s_axi_arready_out     = ~state_q.rvalid;
   assign s_axi_rvalid_out      = state_q.rvalid;
   assign s_axi_rdata_out       = state_q.rdata;
   assign s_axi_rresp_out       = state_q.rresp;
   assign irq_out               = |(state_q.stat & state_q.mask);

endmodule

`default_nettype wire

// ===== iox_regs.svh
`ifndef IOX_REGS_SVH
`define IOX_REGS_SVH

// Register bus byte offsets
`define IOX_OFS_IRQ_STAT  8'h00
`define IOX_OFS_IRQ_MASK  8'h04
`define IOX_OFS_STATUS    8'h08
`define IOX_OFS_PORTS     8'h0c

// Interrupt event bit positions
`define IOX_EV_ALERT      0
`define IOX_EV_WRITE      1
`define IOX_EV_READ       2

// AXI responses
`define IOX_RESP_OKAY     2'h0
`define IOX_RESP_SLVERR   2'h2

// Register-select byte, bits [2:1] = register kind, bit 0 = port
`define IOX_KIND_INPUT    2'h0
`define IOX_KIND_OUTPUT   2'h1
`define IOX_KIND_POL      2'h2
`define IOX_KIND_DIR      2'h3

// Reset values, direction bit high means input
`define IOX_DIR_RST       8'hff
`define IOX_OUT_RST       8'hff
`define IOX_POL_RST       8'h00

// Fixed top bit of the target address
`define IOX_ADDR_HI       1'h1

// Timing: core clock period and longest spike to suppress
`define IOX_CORE_NS       100
`define IOX_SPIKE_NS      50
`define IOX_FILT_CYC      ((`IOX_SPIKE_NS + `IOX_CORE_NS - 1) / `IOX_CORE_NS)

`endif

// ===== iox_pkg.sv
`default_nettype none

package iox_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RXB  = 5'h02,
      ST_ACK  = 5'h04,
      ST_TXB  = 5'h08,
      ST_RACK = 5'h10
   } iox_state_e;

   typedef struct packed {
      logic [1:0][1:0] sy;
      logic [1:0][3:0] cnt;
      logic [1:0]      f;
      logic [1:0]      lp;
      logic [1:0][7:0] pin_s1;
      logic [1:0][7:0] pin_s2;
      logic [5:0]      strap_s1;
      logic [5:0]      strap_s2;
      logic [1:0]      strap_cnt;
      logic [6:0]      my_addr;
      iox_state_e      st;
      logic [3:0]      bitc;
      logic [7:0]      sh;
      logic [1:0]      phase;
      logic            rw;
      logic            nack;
      logic [2:0]      sel;
      logic            sda_oe_n;
      logic [1:0][7:0] dir;
      logic [1:0][7:0] outv;
      logic [1:0][7:0] pol;
      logic [1:0][7:0] held;
      logic            alert;
      logic [2:0]      stat;
      logic [2:0]      mask;
      logic            aw_ok;
      logic            w_ok;
      logic [7:0]      awa;
      logic [31:0]     wd;
      logic            wstb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } iox_regs_s;

endpackage

`default_nettype wire

// ===== iox_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module iox_monitor (
   // Clock and reset
   input wire logic       core_clk_in,
   input wire logic       rst_n_in,
   // Register bus
   input wire logic       s_axi_awvalid_in,
   input wire logic       s_axi_awready_out,
   input wire logic       s_axi_wvalid_in,
   input wire logic       s_axi_wready_out,
   input wire logic       s_axi_bvalid_out,
   input wire logic       s_axi_bready_in,
   input wire logic       s_axi_arvalid_in,
   input wire logic       s_axi_arready_out,
   input wire logic       s_axi_rvalid_out,
   input wire logic       s_axi_rready_in,
   // Pins, link and alert
   input wire logic [7:0] port_a_pin_out,
   input wire logic [7:0] port_a_pin_oe_n_out,
   input wire logic [7:0] port_b_pin_out,
   input wire logic [7:0] port_b_pin_oe_n_out,
   input wire logic       sda_oe_n_out,
   input wire logic       change_alert_n_out,
   input wire logic       change_alert_oe_n_out,
   input wire logic       irq_out
);
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   dir_rst_a: assert property ($rose(rst_n_in) |->
      (port_a_pin_oe_n_out & port_b_pin_oe_n_out) == 8'hff) else $error("pin driven at reset");
   out_rst_a: assert property ($rose(rst_n_in) |->
      (port_a_pin_out & port_b_pin_out) == 8'hff && !irq_out) else $error("bad reset value");
   quiet_rst_a: assert property ($rose(rst_n_in) |->
      (change_alert_oe_n_out && sda_oe_n_out) [*2]) else $error("glitch after reset");
   alert_od_a: assert property (change_alert_n_out == 1'b0)
      else $error("alert drives high");
   wr_ack_a: assert property (s_axi_awvalid_in && s_axi_awready_out &&
      s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("no write reply");
   b_done_a: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
      !s_axi_bvalid_out) else $error("write reply stuck");
   aw_busy_a: assert property (s_axi_bvalid_out |->
      !s_axi_awready_out && !s_axi_wready_out) else $error("second write taken");
   rd_ack_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
      s_axi_rvalid_out) else $error("no read reply");
   r_done_a: assert property (s_axi_rvalid_out && s_axi_rready_in |=>
      !s_axi_rvalid_out) else $error("read reply stuck");
   one_rd_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("second read taken");

   cover property (s_axi_bvalid_out && s_axi_bready_in);
   cover property (!change_alert_oe_n_out);
   cover property (!sda_oe_n_out);
   cover property (irq_out);
endmodule

`default_nettype wire

// ===== iox_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none

module iox_i2c_mst (
   // Core clock paces the bit timing
   input  wire logic clk_in,
   // Open-drain link
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_oe_n_out
);
   initial begin
      scl_out = 1'b1;
      sda_oe_n_out = 1'b1;
   end

   task automatic q(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Low and high 500 ns each, never above 1 MHz
   task automatic bit_io(input logic b, output logic r);
      q(2);
      sda_oe_n_out <= b;
      q(3);
      scl_out <= 1'b1;
      q(2);
      r = sda_in;
      q(3);
      scl_out <= 1'b0;
   endtask

   task automatic start();
      q(2);
      sda_oe_n_out <= 1'b1;
      q(4);
      scl_out <= 1'b1;
      q(3);
      sda_oe_n_out <= 1'b0;
      q(3);
      scl_out <= 1'b0;
   endtask

   task automatic stop();
      q(2);
      sda_oe_n_out <= 1'b0;
      q(4);
      scl_out <= 1'b1;
      q(3);
      sda_oe_n_out <= 1'b1;
      q(3);
   endtask

   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                       output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], b);
         r[i] = b;
      end
      bit_io(last, b);
      ack = !b;
   endtask
endmodule

`default_nettype wire

// ===== test_i2c_sixteen_bit_io_expander.sv
`timescale 1ns/1ps
`default_nettype none
`include "iox_regs.svh"

module test_i2c_sixteen_bit_io_expander;
   logic        core_clk_in, rst_n_in, ce_in, scl_in, sda_in, sda_out, sda_oe_n_out, m_sda;
   logic [1:0]  addr_strap_0_in, addr_strap_1_in, addr_strap_2_in;
   logic [7:0]  port_a_pin_in, port_a_pin_out, port_a_pin_oe_n_out, ext_a;
   logic [7:0]  port_b_pin_in, port_b_pin_out, port_b_pin_oe_n_out, ext_b;
   logic        change_alert_n_out, change_alert_oe_n_out, irq_out;
   logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
   logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
   logic        s_axi_rvalid_out, s_axi_rready_in;
   logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, q;
   logic [3:0]  s_axi_wstrb_in;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
   logic [15:0] q16;
   logic [6:0]  dev = 7'h67;
   logic        a;
   logic [15:0] cfg [1:3] = '{16'h3ca5, 16'h00ff, 16'hf00f};
   int          n_fail = 0;
   int          cmp_count = 0;

   assign sda_in = m_sda & sda_oe_n_out;
   assign port_a_pin_in = (port_a_pin_out & ~port_a_pin_oe_n_out) | (ext_a & port_a_pin_oe_n_out);
   assign port_b_pin_in = (port_b_pin_out & ~port_b_pin_oe_n_out) | (ext_b & port_b_pin_oe_n_out);

   iox_top u_dut (.core_clk_in, .rst_n_in, .ce_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out,
      .addr_strap_0_in, .addr_strap_1_in, .addr_strap_2_in, .port_a_pin_in, .port_a_pin_out,
      .port_a_pin_oe_n_out, .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe_n_out,
      .change_alert_n_out, .change_alert_oe_n_out, .s_axi_awvalid_in, .s_axi_awready_out,
      .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
      .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in,
      .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in,
      .s_axi_rdata_out, .s_axi_rresp_out, .irq_out);

   iox_i2c_mst u_mst (.clk_in(core_clk_in), .sda_in(sda_in), .scl_out(scl_in),
      .sda_oe_n_out(m_sda));

   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic axi(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                      output logic [31:0] rq, output logic [1:0] rr);
      int n;
      s_axi_awaddr_in <= ad;
      s_axi_araddr_in <= ad;
      s_axi_wdata_in <= d;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {3{wr}};
      {s_axi_arvalid_in, s_axi_rready_in} <= {2{!wr}};
      for (n = 0; n < 64; n++) begin
         @(posedge core_clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
         if (wr ? s_axi_bvalid_out : s_axi_rvalid_out) break;
      end
      rq = s_axi_rdata_out;
      rr = wr ? s_axi_bresp_out : s_axi_rresp_out;
      {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
      @(posedge core_clk_in);
      if (n == 64) begin
         n_fail++;
         test_done();
      end
   endtask

   task automatic lk(input logic rd, input logic [7:0] sel, input logic [15:0] d,
                     output logic [15:0] rq);
      u_mst.start();
      u_mst.xfer({dev, 1'b0}, 1'b1, rq[7:0], a);
      chk(a, 1'b1);
      u_mst.xfer(sel, 1'b1, rq[7:0], a);
      if (rd) begin
         u_mst.start();
         u_mst.xfer({dev, 1'b1}, 1'b1, rq[7:0], a);
         u_mst.xfer(8'hff, 1'b0, rq[7:0], a);
         u_mst.xfer(8'hff, 1'b1, rq[15:8], a);
      end else begin
         u_mst.xfer(d[7:0], 1'b1, rq[7:0], a);
         u_mst.xfer(d[15:8], 1'b1, rq[15:8], a);
      end
      u_mst.stop();
   endtask

   task automatic wait_alert(input logic lvl);
      int n;
      for (n = 0; n < 40 && change_alert_oe_n_out !== lvl; n++) @(posedge core_clk_in);
      chk(change_alert_oe_n_out, lvl);
      if (n == 40) test_done();
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      {rst_n_in, ce_in, ext_a, ext_b, s_axi_wstrb_in} = {2'b01, 16'h0, 4'hf};
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 3'h0;
      {s_axi_bready_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = 18'h0;
      s_axi_wdata_in = 32'h0;
      {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in} = 6'h27;
      repeat (12) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      chk({port_b_pin_oe_n_out, port_a_pin_oe_n_out}, 16'hffff);
      axi(0, `IOX_OFS_PORTS, 32'h0, q, r);
      chk(q, 32'hffff0000);
      axi(0, `IOX_OFS_STATUS, 32'h0, q, r);
      chk(q[6:0], 7'h67);
      axi(1, 8'h10, 32'h1, q, r);
      chk(r, `IOX_RESP_SLVERR);
      axi(0, 8'h10, 32'h0, q, r);
      chk({q[29:0], r}, {30'h0, `IOX_RESP_SLVERR});
      $display("test reset done");
      for (int k = 1; k < 4; k++) lk(0, {5'h0, k[1:0], 1'b0}, cfg[k], q16);
      for (int k = 1; k < 4; k++) begin
         lk(1, {5'h0, k[1:0], 1'b0}, 16'h0, q16);
         chk(q16, cfg[k]);
      end
      chk({port_b_pin_oe_n_out, port_a_pin_oe_n_out}, 16'hf00f);
      chk({port_b_pin_out, port_a_pin_out}, 16'h3ca5);
      axi(0, `IOX_OFS_IRQ_STAT, 32'h0, q, r);
      chk(q, 32'h2);
      chk(irq_out, 1'b0);
      axi(1, `IOX_OFS_IRQ_MASK, 32'h2, q, r);
      chk(irq_out, 1'b1);
      axi(1, `IOX_OFS_IRQ_STAT, 32'h2, q, r);
      chk(irq_out, 1'b0);
      s_axi_wstrb_in <= 4'he;
      axi(1, `IOX_OFS_IRQ_MASK, 32'h0, q, r);
      chk(r, `IOX_RESP_OKAY);
      s_axi_wstrb_in <= 4'hf;
      axi(0, `IOX_OFS_IRQ_MASK, 32'h0, q, r);
      chk(q, 32'h2);
      $display("test config done");
      ext_a <= 8'h05;
      wait_alert(1'b0);
      lk(1, 8'h00, 16'h0, q16);
      chk(q16, 16'h0c5a);
      wait_alert(1'b1);
      lk(0, 8'h00, 16'h7777, q16);
      axi(0, `IOX_OFS_PORTS, 32'h0, q, r);
      chk(q, 32'h3ca50ca5);
      axi(0, `IOX_OFS_IRQ_STAT, 32'h0, q, r);
      chk(q & 32'h5, 32'h5);
      ext_a <= 8'h04;
      wait_alert(1'b0);
      ext_a <= 8'h05;
      wait_alert(1'b1);
      $display("test alert done");
      u_mst.start();
      u_mst.xfer(8'h4e, 1'b1, q16[7:0], a);
      chk(a, 1'b0);
      u_mst.stop();
      $display("test address done");
      rst_n_in <= 1'b0;
      {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in} <= 6'h0;
      repeat (3) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      chk({port_b_pin_oe_n_out, port_a_pin_oe_n_out}, 16'hffff);
      chk({port_b_pin_out, port_a_pin_out}, 16'hffff);
      axi(0, `IOX_OFS_STATUS, 32'h0, q, r);
      chk(q[6:0], 7'h40);
      dev = 7'h40;
      lk(0, 8'h02, 16'h1234, q16);
      chk({port_b_pin_out, port_a_pin_out}, 16'h1234);
      $display("test rerun done");
      test_done();
   end
endmodule

bind iox_top iox_monitor u_mon (.core_clk_in, .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out,
   .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
   .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .port_a_pin_out,
   .port_a_pin_oe_n_out, .port_b_pin_out, .port_b_pin_oe_n_out, .sda_oe_n_out,
   .change_alert_n_out, .change_alert_oe_n_out, .irq_out);

`default_nettype wire
